/* File: hw/ehc_counter.sv */
// Encoder up/down counter with hardware and software compare outputs
// Functional notes
// - Outside one-phase single-input software mode the direction comes from the inputs themselves.
// - One-phase single-input hardware mode counts up with phase A off and down with it on.
// - One-phase single-input software mode takes the direction from word 1, 0 up and 1 down.
// - In 32-bit range the count is signed and wraps over the full two's-complement span.
// - In 16-bit range the count runs from zero to the limit held in word 2.
// - Each compare output is set when the present value becomes equal to its compare value.
// - A set compare output stays on until a reset command for it turns it off.
// - The hardware compare output is set straight from the match logic.
// - The software compare output is set once a wait of SW_DELAY_CYC enabled cycles after a match ends, 300 us by default.
// - While count disable is high phase pulses do not change the count.
// - Writing the mode word at location 0 reloads locations 1 to 14 with defaults; the flags word at 15 keeps its bits.
`timescale 1ns/10ps
`default_nettype none
module ehc_counter #(
  parameter int SW_DELAY_CYC = ehc_pkg::EHC_SW_LAT_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic phase_a_i,
  input wire logic phase_b_i,
  input wire logic preset_i,
  input wire logic count_disable_i,
  input wire logic [ehc_pkg::EHC_ADDR_W-1:0] buf_addr_i,
  input wire logic [ehc_pkg::EHC_DATA_W-1:0] buf_wdata_i,
  input wire logic buf_wr_i,
  input wire logic buf_rd_i,
  output logic [ehc_pkg::EHC_DATA_W-1:0] buf_rdata_o,
  output logic hardware_compare_output_o,
  output logic software_compare_output_o,
  output logic irq_o
);
  import ehc_pkg::*;

  localparam logic [EHC_TMR_W-1:0] TMR_LAST = EHC_TMR_W'(SW_DELAY_CYC - 1);

  logic [15:0] mode;
  logic sw_dir;
  logic [15:0] lim;
  logic [31:0] preset_val;
  logic [31:0] hcmp;
  logic [31:0] scmp;
  logic cnt_en;
  logic pre_en;
  logic [EHC_ST_W-1:0] mask;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic cnt_upd;
  logic preset_q;
  logic last_up;
  logic last_dn;
  logic sw_pend;
  logic [EHC_TMR_W-1:0] sw_tmr;
  logic [EHC_ST_W-1:0] stat;
  logic [EHC_ST_W-1:0] st_ev;
  logic w16;
  ehc_kind_t kind;
  logic dec_up;
  logic dec_dn;
  logic step_up;
  logic step_dn;
  logic preset_ev;
  logic wr;
  logic mode_wr;
  logic cmd_wr;
  logic hw_set;
  logic sw_match;
  logic sw_set;
  logic hw_rst_wr;
  logic sw_rst_wr;

  assign wr = ce_i & buf_wr_i;
  assign mode_wr = wr & (buf_addr_i == EHC_OFS_MODE);
  assign cmd_wr = wr & (buf_addr_i == EHC_OFS_CMD);
  assign hw_rst_wr = cmd_wr & buf_wdata_i[EHC_CMD_HRST];
  assign sw_rst_wr = cmd_wr & buf_wdata_i[EHC_CMD_SRST];
  assign w16 = mode[EHC_MODE_W16_BIT];
  assign kind = ehc_kind_t'(mode[3:1]);

  ehc_phase_dec u_dec (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .phase_a_i(phase_a_i),
    .phase_b_i(phase_b_i),
    .kind_i(kind),
    .sw_down_i(sw_dir),
    .up_o(dec_up),
    .dn_o(dec_dn)
  );

  // Pulses pass only while counting is enabled and not disabled
  assign step_up = ce_i & cnt_en & ~count_disable_i & dec_up;
  assign step_dn = ce_i & cnt_en & ~count_disable_i & dec_dn;
  assign preset_ev = ce_i & ((pre_en & preset_i & ~preset_q) |
                             (cmd_wr & buf_wdata_i[EHC_CMD_SPRE]));

  // Configuration words
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode <= EHC_MODE_RST;
      sw_dir <= 1'b0;
      lim <= EHC_LIM_RST;
      preset_val <= 32'h0000_0000;
      hcmp <= 32'h0000_0000;
      scmp <= 32'h0000_0000;
      cnt_en <= 1'b1;
      pre_en <= 1'b1;
      mask <= '0;
    end else if (mode_wr) begin
      if (buf_wdata_i <= EHC_MODE_MAX) begin
        mode <= buf_wdata_i;
      end
      sw_dir <= 1'b0;
      lim <= EHC_LIM_RST;
      preset_val <= 32'h0000_0000;
      hcmp <= 32'h0000_0000;
      scmp <= 32'h0000_0000;
      cnt_en <= 1'b1;
      pre_en <= 1'b1;
      mask <= '0;
    end else if (wr) begin
      case (buf_addr_i)
        EHC_OFS_SWDIR: sw_dir <= buf_wdata_i[0];
        EHC_OFS_LIM_LO: lim <= buf_wdata_i;
        EHC_OFS_PRE_LO: preset_val[15:0] <= buf_wdata_i;
        EHC_OFS_PRE_HI: preset_val[31:16] <= buf_wdata_i;
        EHC_OFS_HCMP_LO: hcmp[15:0] <= buf_wdata_i;
        EHC_OFS_HCMP_HI: hcmp[31:16] <= buf_wdata_i;
        EHC_OFS_SCMP_LO: scmp[15:0] <= buf_wdata_i;
        EHC_OFS_SCMP_HI: scmp[31:16] <= buf_wdata_i;
        EHC_OFS_CMD: begin
          cnt_en <= buf_wdata_i[EHC_CMD_CNT_EN];
          pre_en <= buf_wdata_i[EHC_CMD_PRE_EN];
        end
        EHC_OFS_MASK: mask <= buf_wdata_i[EHC_ST_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Next present value
  always_comb begin
    next_cnt = cnt;
    if (preset_ev) begin
      next_cnt = w16 ? {16'h0000, preset_val[15:0]} : preset_val;
    end else if (step_up) begin
      if (w16) begin
        next_cnt = (cnt[15:0] >= lim) ? 32'h0000_0000 :
                   {16'h0000, cnt[15:0] + 16'h0001};
      end else begin
        next_cnt = cnt + 32'h0000_0001;
      end
    end else if (step_dn) begin
      if (w16) begin
        next_cnt = (cnt[15:0] == 16'h0000) ? {16'h0000, lim} :
                   {16'h0000, cnt[15:0] - 16'h0001};
      end else begin
        next_cnt = cnt - 32'h0000_0001;
      end
    end
  end

  // Present value register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt <= 32'h0000_0000;
      cnt_upd <= 1'b0;
    end else if (ce_i) begin
      if (mode_wr) begin
        cnt <= 32'h0000_0000;
        cnt_upd <= 1'b0;
      end else begin
        cnt <= next_cnt;
        cnt_upd <= preset_ev | step_up | step_dn;
      end
    end
  end

  // Preset edge and direction memory
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      preset_q <= 1'b0;
      last_up <= 1'b0;
      last_dn <= 1'b0;
    end else if (ce_i) begin
      preset_q <= preset_i;
      if (step_up | step_dn) begin
        last_up <= step_up;
        last_dn <= step_dn;
      end
    end
  end

  // Compare matches
  assign hw_set = ce_i & cnt_upd & (cnt == hcmp);
  assign sw_match = ce_i & cnt_upd & (cnt == scmp);
  assign sw_set = ce_i & sw_pend & (sw_tmr == TMR_LAST);

  // Hardware compare output, set wins over reset command
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hardware_compare_output_o <= 1'b0;
    end else if (hw_set) begin
      hardware_compare_output_o <= 1'b1;
    end else if (hw_rst_wr) begin
      hardware_compare_output_o <= 1'b0;
    end
  end

  // Software processing delay after a match
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sw_pend <= 1'b0;
      sw_tmr <= '0;
    end else if (ce_i) begin
      if (sw_set) begin
        sw_pend <= 1'b0;
        sw_tmr <= '0;
      end else if (sw_pend) begin
        sw_tmr <= sw_tmr + 1'b1;
      end else if (sw_match) begin
        sw_pend <= 1'b1;
        sw_tmr <= '0;
      end
    end
  end

  // Software compare output, set wins over reset command
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      software_compare_output_o <= 1'b0;
    end else if (sw_set) begin
      software_compare_output_o <= 1'b1;
    end else if (sw_rst_wr) begin
      software_compare_output_o <= 1'b0;
    end
  end

  // Sticky status bits, write one to clear
  assign st_ev[EHC_ST_HW] = hw_set;
  assign st_ev[EHC_ST_SW] = sw_set;
  assign st_ev[EHC_ST_PRE] = preset_ev;

  for (genvar i = 0; i < EHC_ST_W; i++) begin : g_st
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        stat[i] <= 1'b0;
      end else if (st_ev[i]) begin
        stat[i] <= 1'b1;
      end else if (mode_wr | (wr & (buf_addr_i == EHC_OFS_STAT) & buf_wdata_i[i])) begin
        stat[i] <= 1'b0;
      end
    end
  end

  assign irq_o = |(stat & mask);

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      buf_rdata_o <= '0;
    end else if (ce_i) begin
      buf_rdata_o <= '0;
      if (buf_rd_i) begin
        case (buf_addr_i)
          EHC_OFS_MODE: buf_rdata_o <= mode;
          EHC_OFS_SWDIR: buf_rdata_o <= {15'h0000, sw_dir};
          EHC_OFS_LIM_LO: buf_rdata_o <= lim;
          EHC_OFS_PRE_LO: buf_rdata_o <= preset_val[15:0];
          EHC_OFS_PRE_HI: buf_rdata_o <= preset_val[31:16];
          EHC_OFS_HCMP_LO: buf_rdata_o <= hcmp[15:0];
          EHC_OFS_HCMP_HI: buf_rdata_o <= hcmp[31:16];
          EHC_OFS_SCMP_LO: buf_rdata_o <= scmp[15:0];
          EHC_OFS_SCMP_HI: buf_rdata_o <= scmp[31:16];
          EHC_OFS_CMD: buf_rdata_o <= {14'h0000, pre_en, cnt_en};
          EHC_OFS_CNT_LO: buf_rdata_o <= cnt[15:0];
          EHC_OFS_CNT_HI: buf_rdata_o <= cnt[31:16];
          EHC_OFS_STAT: buf_rdata_o <= {13'h0000, stat};
          EHC_OFS_MASK: buf_rdata_o <= {13'h0000, mask};
          EHC_OFS_FLAGS: begin
            buf_rdata_o[EHC_FL_HW] <= hardware_compare_output_o;
            buf_rdata_o[EHC_FL_SW] <= software_compare_output_o;
            buf_rdata_o[EHC_FL_UP] <= last_up;
            buf_rdata_o[EHC_FL_DN] <= last_dn;
            buf_rdata_o[EHC_FL_PEND] <= sw_pend;
          end
          default: buf_rdata_o <= '0;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence sw_wait_s;
    sw_pend && ce_i && sw_tmr == TMR_LAST;
  endsequence

  sequence sw_done_s;
    software_compare_output_o && !sw_pend;
  endsequence

  p1_hwdir_a: assert property (
    kind == EHC_K_P1HW && dec_up |-> !phase_a_i && !dec_dn)
    else $error("hardware direction count up with phase A on");

  p1_swdir_a: assert property (
    kind == EHC_K_P1SW && step_dn |-> sw_dir && !$past(mode_wr))
    else $error("software direction count down while word 1 is zero");

  quad_dir_a: assert property (
    kind == EHC_K_QX4 && ce_i && dec_up |-> (phase_a_i ^ $past(phase_b_i)) || !$past(ce_i))
    else $error("quadrature direction does not follow phase order");

  cnt32_wrap_a: assert property (
    !w16 && step_up && !preset_ev && !mode_wr && cnt == 32'h7fff_ffff
    |=> cnt == 32'h8000_0000)
    else $error("signed count does not wrap to the most negative value");

  cnt16_wrap_a: assert property (
    w16 && step_up && !preset_ev && !mode_wr && cnt[15:0] >= lim |=> cnt == 32'h0000_0000)
    else $error("16-bit count does not return to zero past the limit");

  cnt16_down_a: assert property (
    w16 && step_dn && !step_up && !preset_ev && !mode_wr && cnt == 32'h0000_0000
    |=> cnt == {16'h0000, $past(lim)})
    else $error("16-bit count does not roll down to the limit");

  hw_set_a: assert property (
    ce_i && cnt_upd && cnt == hcmp |=> hardware_compare_output_o)
    else $error("hardware compare output not set on match");

  hw_hold_a: assert property (
    hardware_compare_output_o && !hw_rst_wr |=> hardware_compare_output_o)
    else $error("hardware compare output dropped without a reset command");

  hw_clear_a: assert property (
    hw_rst_wr && !hw_set |=> !hardware_compare_output_o)
    else $error("hardware compare output not cleared by reset command");

  sw_tmr_a: assert property (
    sw_pend |-> sw_tmr <= TMR_LAST)
    else $error("software compare wait runs past its bound");

  sw_late_a: assert property (
    sw_wait_s |=> sw_done_s)
    else $error("software compare output not set at the end of the wait");

  dis_hold_a: assert property (
    ce_i && count_disable_i && !preset_ev && !mode_wr |=> $stable(cnt))
    else $error("count moved while count disable was high");

  reinit_a: assert property (
    mode_wr |=> lim == EHC_LIM_RST && hcmp == 32'h0000_0000 && cnt == 32'h0000_0000)
    else $error("mode write did not reload the words with defaults");

  preset_a: assert property (
    preset_ev && !mode_wr && !w16 |=> cnt == $past(preset_val) && cnt_upd)
    else $error("preset did not load the present value");
endmodule
`default_nettype wire

/* File: hw/ehc_pkg.sv */
// Package with offsets, fields, reset values and timing of the encoder counter
package ehc_pkg;
  localparam int EHC_ADDR_W = 5;
  localparam int EHC_DATA_W = 16;
  // Word offsets of the buffer memory words
  localparam logic [4:0] EHC_OFS_MODE = 5'h00;
  localparam logic [4:0] EHC_OFS_SWDIR = 5'h01;
  localparam logic [4:0] EHC_OFS_LIM_LO = 5'h02;
  localparam logic [4:0] EHC_OFS_LIM_HI = 5'h03;
  localparam logic [4:0] EHC_OFS_PRE_LO = 5'h04;
  localparam logic [4:0] EHC_OFS_PRE_HI = 5'h05;
  localparam logic [4:0] EHC_OFS_HCMP_LO = 5'h06;
  localparam logic [4:0] EHC_OFS_HCMP_HI = 5'h07;
  localparam logic [4:0] EHC_OFS_SCMP_LO = 5'h08;
  localparam logic [4:0] EHC_OFS_SCMP_HI = 5'h09;
  localparam logic [4:0] EHC_OFS_CMD = 5'h0a;
  localparam logic [4:0] EHC_OFS_CNT_LO = 5'h0b;
  localparam logic [4:0] EHC_OFS_CNT_HI = 5'h0c;
  localparam logic [4:0] EHC_OFS_STAT = 5'h0d;
  localparam logic [4:0] EHC_OFS_MASK = 5'h0e;
  localparam logic [4:0] EHC_OFS_FLAGS = 5'h0f;
  // Mode word: bit 0 selects 16-bit range, bits 3:1 the input kind
  localparam logic [15:0] EHC_MODE_MAX = 16'h000b;
  localparam int EHC_MODE_W16_BIT = 0;
  localparam logic [15:0] EHC_MODE_RST = 16'h0000;
  localparam logic [15:0] EHC_LIM_RST = 16'hffff;
  // Command word bits
  localparam int EHC_CMD_CNT_EN = 0;
  localparam int EHC_CMD_PRE_EN = 1;
  localparam int EHC_CMD_HRST = 2;
  localparam int EHC_CMD_SRST = 3;
  localparam int EHC_CMD_SPRE = 4;
  // Status bits
  localparam int EHC_ST_W = 3;
  localparam int EHC_ST_HW = 0;
  localparam int EHC_ST_SW = 1;
  localparam int EHC_ST_PRE = 2;
  // Flags word bits
  localparam int EHC_FL_HW = 0;
  localparam int EHC_FL_SW = 1;
  localparam int EHC_FL_UP = 2;
  localparam int EHC_FL_DN = 3;
  localparam int EHC_FL_PEND = 4;
  // Timing
  localparam int EHC_CLK_MHZ = 40;
  localparam int EHC_SW_LAT_US = 300;
  localparam int EHC_SW_LAT_CYC = EHC_SW_LAT_US * EHC_CLK_MHZ;
  localparam int EHC_TMR_W = 16;
  typedef enum logic [2:0] {
    EHC_K_QX1 = 3'h0,
    EHC_K_QX2 = 3'h1,
    EHC_K_QX4 = 3'h2,
    EHC_K_P2IN = 3'h3,
    EHC_K_P1HW = 3'h4,
    EHC_K_P1SW = 3'h5
  } ehc_kind_t;
endpackage

/* File: hw/ehc_phase_dec.sv */
// Phase input edge decoder giving up and down count pulses
`timescale 1ns/10ps
`default_nettype none
module ehc_phase_dec (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic phase_a_i,
  input wire logic phase_b_i,
  input wire ehc_pkg::ehc_kind_t kind_i,
  input wire logic sw_down_i,
  output logic up_o,
  output logic dn_o
);
  import ehc_pkg::*;

  logic a_q;
  logic b_q;
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic a_chg;
  logic b_chg;
  logic qdir;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else if (ce_i) begin
      a_q <= phase_a_i;
      b_q <= phase_b_i;
    end
  end

  assign a_rise = phase_a_i & ~a_q;
  assign a_fall = ~phase_a_i & a_q;
  assign b_rise = phase_b_i & ~b_q;
  assign a_chg = phase_a_i ^ a_q;
  assign b_chg = phase_b_i ^ b_q;
  assign qdir = phase_a_i ^ b_q;

  always_comb begin
    up_o = 1'b0;
    dn_o = 1'b0;
    case (kind_i)
      EHC_K_QX1: begin
        up_o = a_rise & ~phase_b_i;
        dn_o = a_fall & ~phase_b_i;
      end
      EHC_K_QX2: begin
        up_o = a_chg & qdir;
        dn_o = a_chg & ~qdir;
      end
      EHC_K_QX4: begin
        up_o = (a_chg ^ b_chg) & qdir;
        dn_o = (a_chg ^ b_chg) & ~qdir;
      end
      EHC_K_P2IN: begin
        up_o = a_rise;
        dn_o = b_rise;
      end
      EHC_K_P1HW: begin
        up_o = b_rise & ~phase_a_i;
        dn_o = b_rise & phase_a_i;
      end
      EHC_K_P1SW: begin
        up_o = b_rise & ~sw_down_i;
        dn_o = b_rise & sw_down_i;
      end
      default: begin
        up_o = 1'b0;
        dn_o = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

/* File: testbench/ehc_enc_model.sv */
// Behavioural incremental encoder driving the phase lines
`timescale 1ns/10ps
`default_nettype none
module ehc_enc_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic step_i,
  input wire logic up_i,
  input wire logic pulse_i,
  input wire logic two_in_i,
  output logic phase_a_o,
  output logic phase_b_o
);
  logic [1:0] pos;
  logic tick;
  // Quadrature position moves one edge per step
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pos <= 2'h0;
    end else if (step_i) begin
      pos <= up_i ? pos + 2'h1 : pos - 2'h1;
    end
  end
  // One-cycle count pulse per step in the one-phase modes
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick <= 1'b0;
    end else begin
      tick <= step_i;
    end
  end
  always_comb begin
    if (!pulse_i) begin
      phase_a_o = pos[1] ^ pos[0];
      phase_b_o = pos[1];
    end else if (two_in_i) begin
      phase_a_o = tick & up_i;
      phase_b_o = tick & ~up_i;
    end else begin
      phase_a_o = ~up_i;
      phase_b_o = tick;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for the encoder counter
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ehc_pkg::*;
  localparam int SWD = 12;
  localparam int P_HW = 0;
  localparam int P_SW = 1;
  localparam int P_IRQ = 2;
  logic clk_i = 1'b0;
  logic ce = 1'b1;
  logic sys_rst_i = 1'b1;
  logic preset_i = 1'b0;
  logic count_disable_i = 1'b0;
  logic [4:0] buf_addr_i = 5'h00;
  logic [15:0] buf_wdata_i = 16'h0000;
  logic buf_wr_i = 1'b0;
  logic buf_rd_i = 1'b0;
  logic [15:0] buf_rdata_o;
  logic hw_o;
  logic sw_o;
  logic irq_o;
  logic phase_a;
  logic phase_b;
  logic step = 1'b0;
  logic up = 1'b1;
  logic pulse = 1'b0;
  logic two_in = 1'b0;
  logic rd_pend = 1'b0;
  logic [15:0] exp_q[$];
  logic [31:0] rval;
  int err_total = 0;
  int compares = 0;
  int seed = 47;
  int n;
  always #12.5 clk_i = ~clk_i;
  ehc_counter #(.SW_DELAY_CYC(SWD)) i_ehc_counter (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .phase_a_i(phase_a),
    .phase_b_i(phase_b), .preset_i(preset_i), .count_disable_i(count_disable_i),
    .buf_addr_i(buf_addr_i), .buf_wdata_i(buf_wdata_i), .buf_wr_i(buf_wr_i),
    .buf_rd_i(buf_rd_i), .buf_rdata_o(buf_rdata_o), .hardware_compare_output_o(hw_o),
    .software_compare_output_o(sw_o), .irq_o(irq_o));
  ehc_enc_model i_ehc_enc_model (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .step_i(step), .up_i(up), .pulse_i(pulse),
    .two_in_i(two_in), .phase_a_o(phase_a), .phase_b_o(phase_b));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge clk_i) begin
    if (rd_pend) begin
      if (exp_q.size() == 0) begin
        chk(buf_rdata_o, 16'hdead);
      end else begin
        chk(buf_rdata_o, exp_q.pop_front());
      end
    end
    rd_pend <= buf_rd_i;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    buf_wr_i <= 1'b1;
    buf_addr_i <= a;
    buf_wdata_i <= d;
    @(posedge clk_i);
    buf_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk_i);
    buf_rd_i <= 1'b1;
    buf_addr_i <= a;
    exp_q.push_back(e);
    @(posedge clk_i);
    buf_rd_i <= 1'b0;
  endtask
  // Pin is sampled after the wait, not when the task is called
  task automatic pin(input int sel, input logic exp);
    logic got;
    repeat (2) @(negedge clk_i);
    got = (sel == P_HW) ? hw_o : ((sel == P_SW) ? sw_o : irq_o);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic stp(input int cnt, input logic u);
    @(posedge clk_i);
    up <= u;
    repeat (cnt) begin
      @(posedge clk_i);
      step <= 1'b1;
      @(posedge clk_i);
      step <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    chk(16'h0000, 16'h0001);
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(EHC_OFS_MODE, 16'h0000);
    rd(EHC_OFS_LIM_LO, 16'hffff);
    rd(EHC_OFS_CMD, 16'h0003);
    rd(EHC_OFS_MASK, 16'h0000);
    rd(5'h1f, 16'h0000);
    pin(P_HW, 1'b0);
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      wr(EHC_OFS_MODE, 16'(k * 2));
      stp(8, 1'b1);
      rd(EHC_OFS_CNT_LO, 16'(2 << k));
      stp(4, 1'b0);
      rd(EHC_OFS_CNT_LO, 16'(1 << k));
    end
    @(posedge clk_i);
    count_disable_i <= 1'b1;
    stp(4, 1'b1);
    rd(EHC_OFS_CNT_LO, 16'h0004);
    count_disable_i <= 1'b0;
    $display("test quadrature done");
    pulse <= 1'b1;
    wr(EHC_OFS_MODE, 16'h0008);
    stp(3, 1'b1);
    stp(1, 1'b0);
    // A pulse while the clock enable is low is not counted
    ce <= 1'b0;
    stp(1, 1'b1);
    ce <= 1'b1;
    rd(EHC_OFS_CNT_LO, 16'h0002);
    two_in <= 1'b1;
    wr(EHC_OFS_MODE, 16'h0006);
    stp(2, 1'b1);
    stp(1, 1'b0);
    rd(EHC_OFS_CNT_LO, 16'h0001);
    two_in <= 1'b0;
    wr(EHC_OFS_MODE, 16'h000a);
    wr(EHC_OFS_SWDIR, 16'h0001);
    stp(2, 1'b1);
    rd(EHC_OFS_CNT_LO, 16'hfffe);
    rd(EHC_OFS_CNT_HI, 16'hffff);
    wr(EHC_OFS_SWDIR, 16'h0000);
    stp(1, 1'b1);
    rd(EHC_OFS_CNT_LO, 16'hffff);
    $display("test one-phase done");
    wr(EHC_OFS_MODE, 16'h0009);
    wr(EHC_OFS_LIM_LO, 16'h0003);
    stp(4, 1'b1);
    rd(EHC_OFS_CNT_LO, 16'h0000);
    pin(P_HW, 1'b1);
    stp(1, 1'b0);
    rd(EHC_OFS_CNT_LO, 16'h0003);
    wr(EHC_OFS_MODE, 16'h0008);
    wr(EHC_OFS_PRE_LO, 16'hffff);
    wr(EHC_OFS_PRE_HI, 16'h7fff);
    wr(EHC_OFS_CMD, 16'h0013);
    rd(EHC_OFS_CNT_HI, 16'h7fff);
    stp(1, 1'b1);
    rd(EHC_OFS_CNT_HI, 16'h8000);
    rd(EHC_OFS_CNT_LO, 16'h0000);
    rval = $random(seed);
    wr(EHC_OFS_PRE_LO, rval[15:0]);
    wr(EHC_OFS_PRE_HI, rval[31:16]);
    preset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    preset_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(EHC_OFS_CNT_LO, rval[15:0]);
    rd(EHC_OFS_CNT_HI, rval[31:16]);
    $display("test range and preset done");
    wr(EHC_OFS_MODE, 16'h0008);
    // Outputs set by the earlier wrap to zero are cleared first
    wr(EHC_OFS_CMD, 16'h000f);
    pin(P_SW, 1'b0);
    wr(EHC_OFS_HCMP_LO, 16'h0003);
    wr(EHC_OFS_HCMP_HI, 16'h0000);
    wr(EHC_OFS_SCMP_LO, 16'h0005);
    wr(EHC_OFS_SCMP_HI, 16'h0000);
    wr(EHC_OFS_STAT, 16'h0007);
    wr(EHC_OFS_MASK, 16'h0001);
    stp(2, 1'b1);
    pin(P_HW, 1'b0);
    stp(1, 1'b1);
    pin(P_HW, 1'b1);
    pin(P_IRQ, 1'b1);
    rd(EHC_OFS_FLAGS, 16'h0005);
    rd(EHC_OFS_STAT, 16'h0001);
    stp(1, 1'b1);
    pin(P_HW, 1'b1);
    wr(EHC_OFS_STAT, 16'h0001);
    pin(P_IRQ, 1'b0);
    wr(EHC_OFS_CMD, 16'h0007);
    pin(P_HW, 1'b0);
    stp(1, 1'b1);
    pin(P_SW, 1'b0);
    n = 0;
    while (sw_o !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    pin(P_SW, 1'b1);
    chk(16'(n <= SWD + 4), 16'h0001);
    wr(EHC_OFS_CMD, 16'h000b);
    pin(P_SW, 1'b0);
    $display("test compare done");
    wr(EHC_OFS_LIM_LO, 16'h0005);
    wr(EHC_OFS_MODE, 16'h0008);
    rd(EHC_OFS_LIM_LO, 16'hffff);
    wr(EHC_OFS_MODE, 16'h000c);
    rd(EHC_OFS_MODE, 16'h0008);
    rd(EHC_OFS_LIM_HI, 16'h0000);
    wr(EHC_OFS_CNT_LO, 16'h1234);
    rd(EHC_OFS_CNT_LO, 16'h0000);
    $display("test mode reload done");
    repeat (3) @(posedge clk_i);
    wrap_up();
  end
endmodule
`default_nettype wire
